// [hw/fcs_flash_regs.v]
// Behaviour
// - config upper three bits read/write, rest zero
// - key window writes start command if disabled
// - key enable makes key writes compare, invalid reads
// - protection byte loaded from storage at reset
// - protection readable, user writes ignored, debug writes
// - protect select sets unprotected end, refuse protected
// - disable bit zero protects, one protects nothing
// - status bits 3,1,0 read zero
// - buffer empty clears on non-burst launch or buffered burst
// - only burst buffered, empty flag shows room
// - complete flag sets when idle, clears launch
// - violation flag sets, command dropped, write-one clears
// - access error on sequence, divider, stop faults
// - access error cleared by writing one
// - blank flag set on erased blank check
// - command register write-only, reads zero, resets zero
// - five legal command codes recognised
// - 0x40 page erase, 0x41 mass erase
// - other codes illegal, set access error
// - blank check or key unlocks security code
// - timing clock is bus over prescale and divisor
`timescale 1ns/10ps
`include "fcs_consts.vh"
module fcs_flash_regs #(
    parameter AW = 16
) (
    input  wire          i_clock,
    input  wire          i_resetn,
    input  wire          i_psel,
    input  wire          i_penable,
    input  wire          i_pwrite,
    input  wire [11:0]   i_paddr,
    input  wire [31:0]   i_pwdata,
    output wire          o_pready,
    output wire          o_pslverr,
    output reg  [31:0]   o_prdata,
    input  wire [7:0]    i_nv_protection_byte,
    input  wire          i_bdm_prot_we,
    input  wire [7:0]    i_bdm_prot_data,
    input  wire          i_stop_req,
    input  wire          i_array_blank,
    input  wire          i_key_match,
    output reg           o_key_write,
    output reg  [7:0]    o_key_data,
    output wire          o_read_invalid,
    output wire [1:0]    o_security_state_code,
    output reg           o_op_start,
    output reg  [7:0]    o_op_cmd,
    output reg  [AW-1:0] o_op_addr,
    output reg  [7:0]    o_op_data,
    output reg           o_timing_pulse,
    output wire          o_busy
);
    localparam S_IDLE = 2'd0;
    localparam S_DATA = 2'd1;
    localparam S_CMD  = 2'd2;
    localparam E_IDLE = 1'b0;
    localparam E_RUN  = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire acc = i_psel && i_penable;
    wire wr  = acc && i_pwrite;
    assign o_pready  = 1'b1;
    reg    sel_div;
    reg    sel_cfg;
    reg    sel_stat;
    reg    sel_cmd;
    reg    sel_array;
    reg    hit;
    always @* begin
        sel_div   = 1'b0;
        sel_cfg   = 1'b0;
        sel_stat  = 1'b0;
        sel_cmd   = 1'b0;
        sel_array = 1'b0;
        hit       = 1'b1;
        if (i_paddr == `FCS_OFF_DIV)
            sel_div = 1'b1;
        else if (i_paddr == `FCS_OFF_CFG)
            sel_cfg = 1'b1;
        else if (i_paddr == `FCS_OFF_STAT)
            sel_stat = 1'b1;
        else if (i_paddr == `FCS_OFF_CMD)
            sel_cmd = 1'b1;
        else if (i_paddr == `FCS_OFF_ARRAY)
            sel_array = 1'b1;
        else if ((i_paddr != `FCS_OFF_OPT) && (i_paddr != `FCS_OFF_PROT) &&
                 (i_paddr != `FCS_OFF_KEY))
            hit = 1'b0; // unmapped offsets are refused
    end
    assign o_pslverr = acc && !hit;
    wire w_div   = wr && sel_div;
    wire w_cfg   = wr && sel_cfg;
    wire w_stat  = wr && sel_stat;
    wire w_cmd   = wr && sel_cmd;
    wire w_array = wr && sel_array;

    function is_legal;
        input [7:0] c;
        begin
            is_legal = (c == `FCS_CMD_BLANK) || (c == `FCS_CMD_BYTE) ||
                       (c == `FCS_CMD_BURST) || (c == `FCS_CMD_PAGE) ||
                       (c == `FCS_CMD_MASS);
        end
    endfunction

    function needs_prot;
        input [7:0] c;
        begin
            needs_prot = (c == `FCS_CMD_BYTE) || (c == `FCS_CMD_BURST) ||
                         (c == `FCS_CMD_PAGE) || (c == `FCS_CMD_MASS);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronise pin-level inputs
    reg [1:0] stop_s_r;
    reg [1:0] blank_s_r;
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            stop_s_r  <= 2'h0;
            blank_s_r <= 2'h0;
        end else begin
            stop_s_r  <= {stop_s_r[0], i_stop_req};
            blank_s_r <= {blank_s_r[0], i_array_blank};
        end
    end
    wire stop_q  = stop_s_r[1];
    wire blank_q = blank_s_r[1];

    ////////////////////////////////////////////////////////////////////////
    // config, divider, protection
    reg [7:0] cfg_r;
    reg [6:0] div_r;
    reg       div_written_r;
    reg [7:0] prot_r;
    reg       prot_load_r;
    reg [1:0] sec_r;
    wire key_en = cfg_r[`FCS_CFG_KEYEN];
    assign o_read_invalid        = key_en;
    assign o_security_state_code = sec_r;

    always @(posedge i_clock) begin
        if (!i_resetn) begin
            cfg_r         <= 8'h00;
            div_r         <= 7'h00;
            div_written_r <= 1'b0;
            prot_r        <= 8'h00;
            prot_load_r   <= 1'b1;
        end else begin
            if (w_cfg)
                cfg_r <= i_pwdata[7:0] & `FCS_CFG_MASK;
            if (w_div && !div_written_r) begin
                div_r         <= i_pwdata[6:0];
                div_written_r <= 1'b1;
            end
            prot_load_r <= 1'b0;
            if (prot_load_r)
                prot_r <= i_nv_protection_byte;
            else if (i_bdm_prot_we)
                prot_r <= i_bdm_prot_data;
        end
    end

    // protected region: addresses above the selected end
    function prot_hit;
        input [7:0]    c;
        input [AW-1:0] a;
        reg   [AW-1:0] lim;
        begin
            lim = {prot_r[7:1], {(AW-7){1'b1}}};
            if (prot_r[0])
                prot_hit = 1'b0;
            else if (c == `FCS_CMD_MASS)
                prot_hit = 1'b1;
            else
                prot_hit = needs_prot(c) && (a > lim);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // timing clock divider
    reg [2:0] pre_r;
    reg [5:0] dcnt_r;
    wire pre_tick = div_r[`FCS_DIV_PRE8] ? (pre_r == 3'h7) : 1'b1;
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            pre_r          <= 3'h0;
            dcnt_r         <= 6'h00;
            o_timing_pulse <= 1'b0;
        end else begin
            pre_r          <= pre_r + 3'h1;
            o_timing_pulse <= 1'b0;
            if (pre_tick) begin
                if (dcnt_r >= div_r[5:0]) begin
                    dcnt_r         <= 6'h00;
                    o_timing_pulse <= 1'b1;
                end else begin
                    dcnt_r <= dcnt_r + 6'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequence and execution
    reg [1:0]    seq_r;
    reg [7:0]    cmd_r;
    reg [AW-1:0] addr_r;
    reg [7:0]    data_r;
    reg          buf_full_r;
    reg [7:0]    bcmd_r;
    reg [AW-1:0] baddr_r;
    reg [7:0]    bdata_r;
    reg          exe_r;
    reg [15:0]   pulse_r;
    reg          cbef_r;
    reg          ccf_r;
    reg          pviol_r;
    reg          accerr_r;
    reg          blank_r;

    wire in_key   = (i_pwdata[31:16] >= `FCS_KEY_LO) &&
                    (i_pwdata[31:16] <= `FCS_KEY_HI);
    wire key_wr   = w_array && key_en && in_key;
    wire launch   = w_stat && i_pwdata[`FCS_ST_CBEF] && cbef_r;
    wire seq_bad  = (w_array && !key_wr && seq_r != S_IDLE) ||
                    (w_cmd && seq_r != S_DATA) ||
                    (launch && seq_r != S_CMD);
    wire div_bad  = launch && !div_written_r;
    wire cmd_bad  = launch && !is_legal(cmd_r);
    wire pv_bad   = launch && !div_bad && !cmd_bad &&
                    prot_hit(cmd_r, addr_r);
    wire stop_bad = stop_q && exe_r;
    // only a burst may join a running burst
    wire buf_bad  = launch && exe_r && (cmd_r != `FCS_CMD_BURST);
    wire acc_set  = seq_bad || div_bad || cmd_bad || stop_bad || buf_bad;
    wire go       = launch && !acc_set && !pv_bad && !accerr_r && !pviol_r;
    wire done     = exe_r && (pulse_r == `FCS_OP_PULSES) && o_timing_pulse;
    assign o_busy = exe_r;

    always @(posedge i_clock) begin
        if (!i_resetn) begin
            seq_r      <= S_IDLE;
            cmd_r      <= 8'h00;
            addr_r     <= {AW{1'b0}};
            data_r     <= 8'h00;
            buf_full_r <= 1'b0;
            bcmd_r     <= 8'h00;
            baddr_r    <= {AW{1'b0}};
            bdata_r    <= 8'h00;
            exe_r      <= E_IDLE;
            pulse_r    <= 16'h0000;
            cbef_r     <= 1'b1;
            ccf_r      <= 1'b1;
            pviol_r    <= 1'b0;
            accerr_r   <= 1'b0;
            blank_r    <= 1'b0;
            sec_r      <= `FCS_SEC_SECURE;
            o_op_start <= 1'b0;
            o_op_cmd   <= 8'h00;
            o_op_addr  <= {AW{1'b0}};
            o_op_data  <= 8'h00;
            o_key_write <= 1'b0;
            o_key_data  <= 8'h00;
        end else begin
            o_op_start  <= 1'b0;
            o_key_write <= key_wr;
            if (key_wr)
                o_key_data <= i_pwdata[7:0];
            if (i_key_match)
                sec_r <= `FCS_SEC_UNSEC;
            // sequence tracking
            if (acc_set || pv_bad || go)
                seq_r <= S_IDLE;
            else if (w_array && !key_wr) begin
                seq_r  <= S_DATA;
                addr_r <= i_pwdata[AW+15:16];
                data_r <= i_pwdata[7:0];
            end else if (w_cmd) begin
                seq_r <= S_CMD;
                cmd_r <= i_pwdata[7:0];
            end
            if (go) begin
                ccf_r   <= 1'b0;
                blank_r <= 1'b0;
                if (exe_r) begin
                    // only burst joins a running burst
                    buf_full_r <= 1'b1;
                    bcmd_r     <= cmd_r;
                    baddr_r    <= addr_r;
                    bdata_r    <= data_r;
                    cbef_r     <= 1'b0;
                end else begin
                    exe_r      <= E_RUN;
                    pulse_r    <= 16'h0000;
                    o_op_start <= 1'b1;
                    o_op_cmd   <= cmd_r;
                    o_op_addr  <= addr_r;
                    o_op_data  <= data_r;
                    cbef_r     <= (cmd_r == `FCS_CMD_BURST);
                end
            end else if (done) begin
                if (o_op_cmd == `FCS_CMD_BLANK && blank_q) begin
                    blank_r <= 1'b1;
                    sec_r   <= `FCS_SEC_UNSEC;
                end
                if (buf_full_r) begin
                    buf_full_r <= 1'b0;
                    pulse_r    <= 16'h0000;
                    o_op_start <= 1'b1;
                    o_op_cmd   <= bcmd_r;
                    o_op_addr  <= baddr_r;
                    o_op_data  <= bdata_r;
                    cbef_r     <= 1'b1;
                end else begin
                    exe_r  <= E_IDLE;
                    cbef_r <= 1'b1;
                    ccf_r  <= 1'b1;
                end
            end else begin
                if (exe_r && o_timing_pulse)
                    pulse_r <= pulse_r + 16'h0001;
                if (stop_bad) begin
                    exe_r      <= E_IDLE;
                    buf_full_r <= 1'b0;
                    cbef_r     <= 1'b1;
                    ccf_r      <= 1'b1;
                end
                // a running non-burst keeps the launch off
                if (launch && exe_r && o_op_cmd != `FCS_CMD_BURST)
                    cbef_r <= cbef_r;
            end
            // set wins over clear on both error flags
            if (pv_bad)
                pviol_r <= 1'b1;
            else if (w_stat && i_pwdata[`FCS_ST_PVIOL])
                pviol_r <= 1'b0;
            if (acc_set)
                accerr_r <= 1'b1;
            else if (w_stat && i_pwdata[`FCS_ST_ACCERR])
                accerr_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    wire [7:0] stat_v = {cbef_r, ccf_r, pviol_r, accerr_r, 1'b0,
                         blank_r, 2'b00} & `FCS_ST_MASK;
    always @(posedge i_clock) begin
        if (!i_resetn)
            o_prdata <= 32'h00000000;
        else if (i_psel && !i_penable && !i_pwrite) begin
            if (i_paddr == `FCS_OFF_DIV)
                o_prdata <= {24'h000000, div_written_r, div_r};
            else if (i_paddr == `FCS_OFF_OPT)
                o_prdata <= {30'h0000000, sec_r};
            else if (i_paddr == `FCS_OFF_CFG)
                o_prdata <= {24'h000000, cfg_r};
            else if (i_paddr == `FCS_OFF_PROT)
                o_prdata <= {24'h000000, prot_r};
            else if (i_paddr == `FCS_OFF_STAT)
                o_prdata <= {24'h000000, stat_v};
            else if (i_paddr == `FCS_OFF_CMD)
                o_prdata <= 32'h00000000;
            else
                o_prdata <= 32'h00000000;
        end
    end
endmodule // fcs_flash_regs

// [hw/fcs_consts.vh]
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
// register byte offsets
`define FCS_OFF_DIV       12'h000
`define FCS_OFF_OPT       12'h004
`define FCS_OFF_CFG       12'h008
`define FCS_OFF_PROT      12'h00C
`define FCS_OFF_STAT      12'h010
`define FCS_OFF_CMD       12'h014
`define FCS_OFF_ARRAY     12'h018
`define FCS_OFF_KEY       12'h01C
// field positions
`define FCS_CFG_MASK      8'hE0
`define FCS_CFG_KEYEN     5
`define FCS_ST_CBEF       7
`define FCS_ST_CCF        6
`define FCS_ST_PVIOL      5
`define FCS_ST_ACCERR     4
`define FCS_ST_BLANK      2
`define FCS_ST_MASK       8'hF4
`define FCS_DIV_PRE8      6
// command codes
`define FCS_CMD_BLANK     8'h05
`define FCS_CMD_BYTE      8'h20
`define FCS_CMD_BURST     8'h25
`define FCS_CMD_PAGE      8'h40
`define FCS_CMD_MASS      8'h41
// key window and security
`define FCS_KEY_LO        16'hFFB0
`define FCS_KEY_HI        16'hFFB7
`define FCS_SEC_UNSEC     2'h2
`define FCS_SEC_SECURE    2'h0
// array and timing
`define FCS_PAGE_BYTES    512
`define FCS_PREDIV        8
`define FCS_OP_PULSES     16'h0004
`endif

// [bench/fcs_flash_regs_sva.sv]
`timescale 1ns/10ps
`include "fcs_consts.vh"
module fcs_flash_regs_sva (
    input logic        i_clock,
    input logic        i_resetn,
    input logic        i_psel,
    input logic        i_penable,
    input logic        i_pwrite,
    input logic [11:0] i_paddr,
    input logic [31:0] i_pwdata,
    input logic [31:0] o_prdata,
    input logic        i_stop_req,
    input logic        i_key_match,
    input logic        o_key_write,
    input logic [7:0]  o_key_data,
    input logic        o_read_invalid,
    input logic [1:0]  o_security_state_code,
    input logic        o_op_start,
    input logic        o_busy
);
default clocking cb @(posedge i_clock); endclocking
default disable iff (!i_resetn);
wire rd_acc = i_psel && i_penable && !i_pwrite;
wire wr_acc = i_psel && i_penable && i_pwrite;
////////////////////////////////////////////////////////////////////////
AST_CFG_READ: assert property (
    rd_acc && i_paddr == `FCS_OFF_CFG |-> o_prdata[4:0] == 5'h00)
    else $error("config low bits not zero");
AST_STAT_READ: assert property (
    rd_acc && i_paddr == `FCS_OFF_STAT |-> o_prdata[3] == 1'b0
    && o_prdata[1:0] == 2'h0) else $error("status reserved bits set");
AST_CMD_READ: assert property (
    rd_acc && i_paddr == `FCS_OFF_CMD |-> o_prdata == 32'h0)
    else $error("command register reads nonzero");
AST_INVALID: assert property (
    wr_acc && i_paddr == `FCS_OFF_CFG |=>
    o_read_invalid == $past(i_pwdata[`FCS_CFG_KEYEN]))
    else $error("read invalid not following key enable");
AST_KEY_FWD: assert property (
    o_key_write |-> $past(wr_acc) && o_key_data == $past(i_pwdata[7:0]))
    else $error("key write not from bus write");
AST_KEY_GATE: assert property (
    o_key_write |-> o_read_invalid && !o_op_start)
    else $error("key write while key enable off");
AST_UNSECURE: assert property (
    i_key_match |=> o_security_state_code == `FCS_SEC_UNSEC)
    else $error("security code not unsecured");
AST_START_BUSY: assert property (
    o_op_start |-> o_busy) else $error("start without busy");
AST_STOP_ABORT: assert property (
    o_busy && i_stop_req |-> ##[1:5] !o_busy)
    else $error("stop did not abort command");
COV_KEY: cover property (o_key_write);
COV_START: cover property (o_op_start ##1 o_busy);
COV_STOP: cover property (o_busy && i_stop_req);
endmodule // fcs_flash_regs_sva
bind fcs_flash_regs fcs_flash_regs_sva u_fcs_flash_regs_sva (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .i_stop_req(i_stop_req),
    .i_key_match(i_key_match), .o_key_write(o_key_write),
    .o_key_data(o_key_data), .o_read_invalid(o_read_invalid),
    .o_security_state_code(o_security_state_code),
    .o_op_start(o_op_start), .o_busy(o_busy)
);

// [bench/flash_command_status_regs_tb_top.sv]
`timescale 1ns/10ps
`include "fcs_consts.vh"
module flash_command_status_regs_tb_top;
logic        i_clock, i_resetn, i_psel, i_penable, i_pwrite;
logic [11:0] i_paddr;
logic [31:0] i_pwdata, rdv, rde, rdm, e;
logic [7:0]  i_nv_protection_byte, i_bdm_prot_data, c;
logic        i_bdm_prot_we, i_stop_req, i_array_blank, i_key_match, errv;
wire         o_pready, o_pslverr, o_key_write, o_read_invalid;
wire         o_op_start, o_timing_pulse, o_busy;
wire  [31:0] o_prdata;
wire  [7:0]  o_key_data, o_op_cmd, o_op_data;
wire  [1:0]  o_security_state_code;
wire  [15:0] o_op_addr;
logic [15:0] ua;
logic [31:0] exp_q[$], msk_q[$], op_q[$];
logic [7:0]  key_q[$];
logic [7:0]  cmds[3];
int          n_errors = 0, n_tests = 0, i;
fcs_flash_regs u_fcs_flash_regs (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_prdata(o_prdata), .i_nv_protection_byte(i_nv_protection_byte),
    .i_bdm_prot_we(i_bdm_prot_we), .i_bdm_prot_data(i_bdm_prot_data),
    .i_stop_req(i_stop_req), .i_array_blank(i_array_blank),
    .i_key_match(i_key_match), .o_key_write(o_key_write),
    .o_key_data(o_key_data), .o_read_invalid(o_read_invalid),
    .o_security_state_code(o_security_state_code),
    .o_op_start(o_op_start), .o_op_cmd(o_op_cmd), .o_op_addr(o_op_addr),
    .o_op_data(o_op_data), .o_timing_pulse(o_timing_pulse), .o_busy(o_busy)
);
initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
end
////////////////////////////////////////////////////////////////////////
task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task bad(input string s);
    n_errors++;
    $display("BAD at %0t: %s", $time, s);
endtask
task apb(input [11:0] a, input w, input [31:0] d);
    int k;
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    @(posedge i_clock);
    k = 0;
    while (o_pready !== 1'b1) begin
        k++;
        if (k > 20) begin
            bad("no pready");
            give_verdict;
        end
        @(posedge i_clock);
    end
    rdv = o_prdata;
    errv = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
endtask
task wr(input [11:0] a, input [31:0] d);
    apb(a, 1'b1, d);
endtask
task rd(input [11:0] a, input [31:0] x, input [31:0] m);
    exp_q.push_back(x & m);
    msk_q.push_back(m);
    apb(a, 1'b0, 32'h0);
endtask
// data word, command code, then launch
task launch(input [15:0] a, input [7:0] cc, input go);
    logic [7:0] d;
    d = $urandom;
    if (go) op_q.push_back({cc, a, d});
    wr(`FCS_OFF_ARRAY, {a, 8'h00, d});
    wr(`FCS_OFF_CMD, {24'h0, cc});
    wr(`FCS_OFF_STAT, 32'h80);
endtask
task clr;
    wr(`FCS_OFF_STAT, 32'h30);
endtask
task wait_done;
    int k;
    k = 0;
    do begin
        apb(`FCS_OFF_STAT, 1'b0, 32'h0);
        k++;
    end while (rdv[6] !== 1'b1 && k < 60);
    if (k >= 60) begin
        bad("command never completed");
        give_verdict;
    end
endtask
task pulse(input int s);
    if (s == 0)
        i_key_match <= 1'b1;
    else
        i_bdm_prot_we <= 1'b1;
    @(posedge i_clock);
    i_key_match   <= 1'b0;
    i_bdm_prot_we <= 1'b0;
    @(posedge i_clock);
endtask
// cycles between two timing pulses, once the divider has settled
task gap(input int x);
    int k;
    int g;
    k = 0;
    g = 0;
    repeat (2 * x) @(posedge i_clock);
    while (o_timing_pulse !== 1'b1 && k < 200) begin
        @(posedge i_clock);
        k++;
    end
    do begin
        @(posedge i_clock);
        g++;
    end while (o_timing_pulse !== 1'b1 && g < 200);
    n_tests++;
    if (k >= 200 || g != x) bad("timing pulse period wrong");
endtask
////////////////////////////////////////////////////////////////////////
// read, key and operation results, oldest note first
always @(posedge i_clock) begin
    if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1
        && exp_q.size() > 0) begin
        rde = exp_q.pop_front();
        rdm = msk_q.pop_front();
        n_tests++;
        if ((o_prdata & rdm) !== rde) bad("read data mismatch");
    end
    if (o_key_write === 1'b1) begin
        n_tests++;
        if (key_q.size() == 0) bad("unexpected key write");
        else if (o_key_data !== key_q.pop_front()) bad("key data");
    end
    if (o_op_start === 1'b1) begin
        n_tests++;
        if (op_q.size() == 0) bad("unexpected array operation");
        else begin
            e = op_q.pop_front();
            if (o_op_cmd !== e[31:24] || (e[31:28] == 4'h2 &&
                {o_op_addr, o_op_data} !== e[23:0])) bad("operation mismatch");
        end
    end
end
////////////////////////////////////////////////////////////////////////
initial begin
    {i_psel, i_penable, i_pwrite, i_bdm_prot_we, i_stop_req} = 5'h00;
    {i_key_match, i_array_blank} = 2'h0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_bdm_prot_data = 8'h00;
    i_resetn = 1'b0;
    i_nv_protection_byte = 8'h7E;
    void'($urandom(32'hE022EBDD));
    ua = $urandom & 16'h7FFF;
    cmds = '{`FCS_CMD_BLANK, `FCS_CMD_BYTE, `FCS_CMD_PAGE};
    repeat (16) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clock);
    rd(`FCS_OFF_STAT, 32'hC0, 32'hFF);
    rd(`FCS_OFF_CMD, 32'h0, 32'hFFFFFFFF);
    rd(`FCS_OFF_PROT, 32'h7E, 32'hFF);
    rd(`FCS_OFF_CFG, 32'h0, 32'hFF);
    rd(`FCS_OFF_OPT, 32'h0, 32'h3);
    wr(12'h020, 32'hFFFFFFFF);
    n_tests++;
    if (errv !== 1'b1) bad("unmapped access not refused");
    $display("end of test: reset");
    wr(`FCS_OFF_CFG, 32'hFF);
    rd(`FCS_OFF_CFG, 32'hE0, 32'hFF);
    key_q.push_back(8'hA5);
    wr(`FCS_OFF_ARRAY, {`FCS_KEY_LO + 16'h0003, 16'h00A5});
    pulse(0);
    rd(`FCS_OFF_OPT, 32'h2, 32'h3);
    wr(`FCS_OFF_CFG, 32'h0);
    wr(`FCS_OFF_PROT, 32'h01);
    rd(`FCS_OFF_PROT, 32'h7E, 32'hFF);
    $display("end of test: config and key");
    launch(ua, `FCS_CMD_BYTE, 1'b0);
    rd(`FCS_OFF_STAT, 32'h10, 32'h10);
    wr(`FCS_OFF_STAT, 32'h0);
    rd(`FCS_OFF_STAT, 32'h10, 32'h10);
    wr(`FCS_OFF_STAT, 32'h10);
    rd(`FCS_OFF_STAT, 32'h40, 32'h74);
    wr(`FCS_OFF_DIV, 32'h07);
    gap(7 + 1);
    for (i = 0; i < 3; i++) begin
        c = $urandom;
        if (c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) c = 8'hFF;
        launch(ua, c, 1'b0);
        rd(`FCS_OFF_STAT, 32'h10, 32'h10);
        clr;
    end
    wr(`FCS_OFF_CMD, 32'h20);
    wr(`FCS_OFF_STAT, 32'h80);
    rd(`FCS_OFF_STAT, 32'h10, 32'h10);
    clr;
    $display("end of test: access errors");
    i_array_blank <= 1'b1;
    for (i = 0; i < 3; i++) begin
        launch(ua, cmds[i], 1'b1);
        rd(`FCS_OFF_STAT, 32'h0, 32'h40);
        wait_done;
        rd(`FCS_OFF_STAT, (i == 0) ? 32'hC4 : 32'hC0, 32'hF4);
    end
    $display("end of test: legal commands");
    launch(ua | 16'h8000, `FCS_CMD_BYTE, 1'b0);
    rd(`FCS_OFF_STAT, 32'h20, 32'h30);
    wr(`FCS_OFF_STAT, 32'h20);
    rd(`FCS_OFF_STAT, 32'h0, 32'h20);
    launch(ua, `FCS_CMD_MASS, 1'b0);
    rd(`FCS_OFF_STAT, 32'h20, 32'h20);
    clr;
    i_bdm_prot_data <= 8'h01;
    pulse(1);
    rd(`FCS_OFF_PROT, 32'h01, 32'hFF);
    launch(ua | 16'h8000, `FCS_CMD_BYTE, 1'b1);
    wait_done;
    launch(`FCS_KEY_LO + 16'h0002, `FCS_CMD_BYTE, 1'b1);
    wait_done;
    launch(ua, `FCS_CMD_MASS, 1'b1);
    wait_done;
    rd(`FCS_OFF_STAT, 32'hC0, 32'hF0);
    $display("end of test: protection");
    launch(ua, `FCS_CMD_BURST, 1'b1);
    launch(ua + 16'h0001, `FCS_CMD_BURST, 1'b1);
    rd(`FCS_OFF_STAT, 32'h0, 32'hC0);
    wait_done;
    rd(`FCS_OFF_STAT, 32'hC0, 32'hF0);
    launch(ua, `FCS_CMD_BURST, 1'b1);
    launch(ua, `FCS_CMD_BYTE, 1'b0);
    rd(`FCS_OFF_STAT, 32'h90, 32'h90);
    wait_done;
    clr;
    $display("end of test: burst");
    launch(ua, `FCS_CMD_BYTE, 1'b1);
    i_stop_req <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_stop_req <= 1'b0;
    rd(`FCS_OFF_STAT, 32'h10, 32'h10);
    clr;
    $display("end of test: stop abort");
    i_nv_protection_byte <= $urandom;
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clock);
    rd(`FCS_OFF_PROT, {24'h0, i_nv_protection_byte}, 32'hFF);
    rd(`FCS_OFF_OPT, 32'h0, 32'h3);
    rd(`FCS_OFF_STAT, 32'hC0, 32'hFF);
    wr(`FCS_OFF_DIV, 32'h41);
    gap(`FCS_PREDIV * (1 + 1));
    launch(ua, `FCS_CMD_BLANK, 1'b1);
    wait_done;
    rd(`FCS_OFF_OPT, 32'h2, 32'h3);
    $display("end of test: reset again");
    n_tests++;
    if (op_q.size() != 0 || key_q.size() != 0 || exp_q.size() != 0)
        bad("expected results never seen");
    give_verdict;
end
endmodule // flash_command_status_regs_tb_top
